// ===== tpm_top.sv
// Purpose: table move unit, table-to-destination and remove-from-bottom
// Assumes: one execution request per instruction, held operands during it
// Notes: word memory also reached by a simple host port while idle
`timescale 1ns/100ps
`default_nettype none

module tpm_top
  import tpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic exec_req,
  input wire tpm_op_t exec_op,
  input wire logic exec_enable,
  input wire logic [LEN_W-1:0] table_len,
  input wire logic [ADDR_W-1:0] table_base,
  input wire logic [ADDR_W-1:0] dest_addr,
  input wire logic scan_end,
  input wire logic ext_rd,
  input wire logic ext_wr,
  input wire logic [ADDR_W-1:0] ext_addr,
  input wire logic [DATA_W-1:0] ext_wdata,
  output logic [DATA_W-1:0] ext_rdata,
  output logic ext_ack,
  output logic busy,
  output logic done,
  output logic end_of_table_flag
);
  // ************************************************************
  // helpers
  // ************************************************************

  // word address of entry idx counted from the table base
  function automatic logic [ADDR_W-1:0] entry_addr(
    input logic [ADDR_W-1:0] base,
    input logic [DATA_W-1:0] idx
  );
    entry_addr = base + idx[ADDR_W-1:0];
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  tpm_state_t state_q, state_d;
  tpm_op_t op_q, op_d;
  logic [LEN_W-1:0] len_q, len_d;
  logic [ADDR_W-1:0] base_q, base_d;
  logic [ADDR_W-1:0] dest_q, dest_d;
  logic [DATA_W-1:0] new_ptr_q, new_ptr_d;
  logic ptr_wr_q, ptr_wr_d;
  logic flag_res_q, flag_res_d;
  logic flag_q, flag_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic ack_q, ack_d;

  logic [ADDR_W-1:0] mem_addr;
  logic mem_we;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata;

  // pointer decode results, valid in ST_PTR
  logic [DATA_W-1:0] ptr;
  logic [DATA_W-1:0] len_ext;
  logic [DATA_W-1:0] calc_ptr;
  logic [DATA_W-1:0] calc_idx;
  logic calc_move;
  logic calc_wr;
  logic calc_flag;

  // ************************************************************
  // pointer arithmetic
  // ************************************************************

  // decode the pointer just read from the base word
  always_comb
  begin
    ptr = mem_rdata;
    len_ext = {{(DATA_W-LEN_W){1'b0}}, len_q};
    calc_ptr = ptr;
    calc_idx = PTR_RESTART;
    calc_move = 1'b0;
    calc_wr = 1'b0;
    calc_flag = 1'b0;
    unique case (op_q)
      OP_TABLE_TO_DEST:
      begin
        if ((len_ext == PTR_EMPTY) || (ptr > len_ext))
        begin
          // empty table or pointer outside it: nothing moves
          calc_flag = (ptr == len_ext);
        end
        else
        begin
          // update first, then use the new value as the index
          if (ptr == len_ext)
          begin
            calc_ptr = PTR_RESTART;
          end
          else
          begin
            calc_ptr = ptr + PTR_STEP;
          end
          calc_idx = calc_ptr;
          calc_move = 1'b1;
          calc_wr = 1'b1;
          calc_flag = (calc_ptr == len_ext);
        end
      end
      OP_REMOVE_BOTTOM:
      begin
        if (ptr == PTR_EMPTY)
        begin
          calc_flag = 1'b1;
        end
        else if (ptr <= len_ext)
        begin
          calc_idx = ptr;
          calc_ptr = ptr - PTR_STEP;
          calc_move = 1'b1;
          calc_wr = 1'b1;
          calc_flag = (calc_ptr == PTR_EMPTY);
        end
      end
    endcase
  end

  // ************************************************************
  // sequencer
  // ************************************************************

  // next state, operand capture, memory port steering
  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    len_d = len_q;
    base_d = base_q;
    dest_d = dest_q;
    new_ptr_d = new_ptr_q;
    ptr_wr_d = ptr_wr_q;
    flag_res_d = flag_res_q;
    done_d = 1'b0;
    ack_d = 1'b0;
    mem_addr = ext_addr;
    mem_we = 1'b0;
    mem_wdata = ext_wdata;
    unique case (state_q)
      ST_IDLE:
      begin
        if (exec_req && exec_enable)
        begin
          // start one transfer for this scan
          op_d = exec_op;
          len_d = table_len;
          base_d = table_base;
          dest_d = dest_addr;
          mem_addr = table_base;
          state_d = ST_PTR;
        end
        else if (exec_req)
        begin
          done_d = 1'b1;
        end
        else if (ext_rd || ext_wr)
        begin
          // host access only when no execution competes
          mem_we = ext_wr;
          ack_d = 1'b1;
        end
      end
      ST_PTR:
      begin
        new_ptr_d = calc_ptr;
        ptr_wr_d = calc_wr;
        flag_res_d = calc_flag;
        mem_addr = entry_addr(base_q, calc_idx);
        state_d = calc_move ? ST_DATA : ST_WPTR;
      end
      ST_DATA:
      begin
        // entry word is in the read register now
        mem_addr = dest_q;
        mem_we = 1'b1;
        mem_wdata = mem_rdata;
        state_d = ST_WPTR;
      end
      ST_WPTR:
      begin
        mem_addr = base_q;
        mem_we = ptr_wr_q;
        mem_wdata = new_ptr_q;
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    busy_d = (state_d != ST_IDLE);
  end

  // sequencer registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      op_q <= OP_TABLE_TO_DEST;
      len_q <= '0;
      base_q <= '0;
      dest_q <= '0;
      new_ptr_q <= PTR_EMPTY;
      ptr_wr_q <= 1'b0;
      flag_res_q <= FLAG_RST;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ack_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      len_q <= len_d;
      base_q <= base_d;
      dest_q <= dest_d;
      new_ptr_q <= new_ptr_d;
      ptr_wr_q <= ptr_wr_d;
      flag_res_q <= flag_res_d;
      busy_q <= busy_d;
      done_q <= done_d;
      ack_q <= ack_d;
    end
  end

  // ************************************************************
  // end-of-table flag
  // ************************************************************

  // each executed operation overwrites it in ST_WPTR, end of scan clears it in any other state
  always_comb
  begin
    flag_d = flag_q;
    if (state_q == ST_WPTR)
    begin
      flag_d = flag_res_q;
    end
    else if (scan_end)
    begin
      flag_d = 1'b0;
    end
  end

  // flag register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      flag_q <= FLAG_RST;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  // ************************************************************
  // word memory
  // ************************************************************
  tpm_mem u_mem
  (
    .clk(clk),
    .rst_n(rst_n),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  assign ext_rdata = mem_rdata; // registered inside the memory
  assign ext_ack = ack_q;
  assign busy = busy_q;
  assign done = done_q;
  assign end_of_table_flag = flag_q;
endmodule

`default_nettype wire

// ===== tpm_mem.sv
// Purpose: shared constants and the word memory of the table move unit
// Assumes: one clock, synchronous active-low reset, one access per cycle
// Notes: read data is registered; a read and a write to one word return
//        the old contents
`timescale 1ns/100ps
`default_nettype none

package tpm_pkg;
  // ************************************************************
  // sizes and fixed values
  // ************************************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 10;
  localparam int LEN_W = 8;
  localparam int MEM_DEPTH = 1024;
  localparam logic [DATA_W-1:0] PTR_RESTART = 16'h0001;
  localparam logic [DATA_W-1:0] PTR_STEP = 16'h0001;
  localparam logic [DATA_W-1:0] PTR_EMPTY = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
  localparam logic FLAG_RST = 1'b0;

  // ************************************************************
  // operation codes and sequencer states
  // ************************************************************
  typedef enum logic
  {
    OP_TABLE_TO_DEST = 1'b0,
    OP_REMOVE_BOTTOM = 1'b1
  } tpm_op_t;

  typedef enum logic [3:0]
  {
    ST_IDLE = 4'b0001,
    ST_PTR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_WPTR = 4'b1000
  } tpm_state_t;
endpackage

module tpm_mem
  import tpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic we,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem_q [MEM_DEPTH];
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;

  // read-first: the old word comes out
  always_comb
  begin
    rdata_d = mem_q[addr];
  end

  // storage array, no reset
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_q[addr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdata_q <= RDATA_RST;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
endmodule

`default_nettype wire

// ===== tpm_top_sva.sv
// Purpose: port assertions for the table move unit
// Assumes: one clock, synchronous active-low reset
// Notes: bound to tpm_top from the testbench
`timescale 1ns/100ps
`default_nettype none

module tpm_top_sva
  import tpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic exec_req,
  input wire logic exec_enable,
  input wire logic scan_end,
  input wire logic ext_rd,
  input wire logic ext_wr,
  input wire logic ext_ack,
  input wire logic busy,
  input wire logic done,
  input wire logic end_of_table_flag
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ************************************************************
  // execution timing, flag behaviour and host acknowledge
  // ************************************************************
  a_run_busy_done: assert property (
    exec_req && !busy && exec_enable |=> busy [*2] ##[1:2] (done && !busy))
    else $error("enabled run timing wrong");
  a_off_done_next: assert property (
    exec_req && !busy && !exec_enable |=> done && !busy)
    else $error("disabled run gave no done");
  a_off_flag_hold: assert property (
    exec_req && !busy && !exec_enable && !scan_end
    |=> end_of_table_flag == $past(end_of_table_flag))
    else $error("disabled run moved the flag");
  a_scan_end_clear: assert property (
    scan_end && !busy && !exec_req |=> !end_of_table_flag)
    else $error("scan end left the flag set");
  a_flag_rise_done: assert property (
    $rose(end_of_table_flag) |-> done)
    else $error("flag rose outside done");
  a_flag_still_idle: assert property (
    !done && !$past(scan_end) |-> $stable(end_of_table_flag))
    else $error("flag changed without cause");
  a_busy_fall_done: assert property (
    $fell(busy) |-> done)
    else $error("busy fell without done");
  a_host_ack_next: assert property (
    (ext_rd || ext_wr) && !busy && !exec_req && !done |=> ext_ack)
    else $error("host access not acknowledged");
endmodule

`default_nettype wire

// ===== tb_top.sv
// Purpose: self-checking bench for the table move unit
// Assumes: inputs driven at falling edge, memory seen via host port
// Notes: a reference word array predicts every read and flag
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import tpm_pkg::*;
  localparam logic [ADDR_W-1:0] BASE = 10'h100;
  localparam logic [ADDR_W-1:0] DEST = 10'h200;
  logic clk, rst_n, exec_req, exec_enable, scan_end, ext_rd, ext_wr;
  tpm_op_t exec_op;
  logic [LEN_W-1:0] table_len;
  logic [ADDR_W-1:0] table_base, dest_addr, ext_addr;
  logic [DATA_W-1:0] ext_wdata, ext_rdata;
  logic [DATA_W-1:0] m [0:MEM_DEPTH-1];
  logic ext_ack, busy, done, end_of_table_flag, flag_m, e_flag;
  logic [DATA_W:0] rd_q [$];
  logic [DATA_W:0] e_rd;
  logic flag_q [$];
  logic [31:0] seed = 32'h0f0e;
  int error_cnt, tests_run, cyc;

  tpm_top dut_u (.clk, .rst_n, .exec_req, .exec_op, .exec_enable,
    .table_len, .table_base, .dest_addr, .scan_end, .ext_rd, .ext_wr,
    .ext_addr, .ext_wdata, .ext_rdata, .ext_ack, .busy, .done,
    .end_of_table_flag);

  // ************************************************************
  // clock, random source, reporting
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [DATA_W-1:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[DATA_W-1:0];
  endfunction

  task automatic fail(input string s);
    error_cnt++;
    $display("CHECK FAILED at %0t: %s", $time, s);
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fail("timeout");
      give_verdict();
    end
  end

  // ************************************************************
  // output watcher: oldest note against each result
  // ************************************************************
  always @(negedge clk)
  begin
    if (rst_n && done)
    begin
      tests_run++;
      if (flag_q.size() == 0)
        fail("unexpected done");
      else
      begin
        e_flag = flag_q.pop_front();
        if (end_of_table_flag !== e_flag)
          fail("end flag mismatch");
      end
    end
    if (rst_n && ext_ack && rd_q.size() > 0)
    begin
      e_rd = rd_q.pop_front();
      if (e_rd[DATA_W])
      begin
        tests_run++;
        if (ext_rdata !== e_rd[DATA_W-1:0])
          fail("read data mismatch");
      end
    end
    else if (rst_n && ext_ack)
      fail("unexpected host ack");
  end

  // ************************************************************
  // drivers with reference model
  // ************************************************************
  task automatic host(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    rd_q.push_back({!wr, wr ? d : m[a]});
    if (wr)
      m[a] = d;
    ext_wr = wr;
    ext_rd = !wr;
    ext_addr = a;
    ext_wdata = d;
    // request stays up until the ack is seen at a falling edge
    do
    begin
      @(negedge clk);
      n++;
    end
    while (!ext_ack && n < 20);
    if (ext_ack !== 1'b1)
      fail("no host ack");
    ext_wr = 1'b0;
    ext_rd = 1'b0;
    @(negedge clk);
  endtask

  task automatic run(input tpm_op_t op, input logic en,
                     input logic [LEN_W-1:0] len);
    logic [DATA_W-1:0] p, np;
    int n;
    p = m[BASE];
    n = 0;
    if (en && op == OP_TABLE_TO_DEST)
    begin
      if (len == 0 || p > len)
        flag_m = (p == len);
      else
      begin
        np = (p == len) ? PTR_RESTART : p + PTR_STEP;
        m[DEST] = m[BASE + np[ADDR_W-1:0]];
        m[BASE] = np;
        flag_m = (np == len);
      end
    end
    else if (en)
    begin
      if (p == 0 || p > len)
        flag_m = (p == 0);
      else
      begin
        m[DEST] = m[BASE + p[ADDR_W-1:0]];
        m[BASE] = p - PTR_STEP;
        flag_m = (p == 1);
      end
    end
    flag_q.push_back(flag_m);
    exec_op = op;
    exec_enable = en;
    table_len = len;
    exec_req = 1'b1;
    @(negedge clk);
    exec_req = 1'b0;
    // a lost done must count, not just end the wait
    while (!done && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    if (done !== 1'b1)
      fail("no done");
    @(negedge clk);
    host(1'b0, DEST, 16'h0000);
    host(1'b0, BASE, 16'h0000);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    {exec_req, exec_enable, scan_end, ext_rd, ext_wr} = 5'h00;
    exec_op = OP_TABLE_TO_DEST;
    table_len = 8'h00;
    table_base = BASE;
    dest_addr = DEST;
    ext_addr = 10'h000;
    ext_wdata = 16'h0000;
    flag_m = 1'b0;
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    host(1'b1, DEST, 16'h0000);
    for (int i = 0; i <= 9; i++)
      host(1'b1, BASE + ADDR_W'(i), i == 0 ? 16'h0000 : rnd());
    repeat (6) run(OP_TABLE_TO_DEST, 1'b1, 8'h06);
    run(OP_REMOVE_BOTTOM, 1'b0, 8'h06);
    scan_end = 1'b1;
    flag_m = 1'b0;
    @(negedge clk);
    scan_end = 1'b0;
    run(OP_TABLE_TO_DEST, 1'b0, 8'h06);
    repeat (2) run(OP_TABLE_TO_DEST, 1'b1, 8'h06);
    $display("test table to destination done");
    host(1'b1, BASE, 16'h0009);
    run(OP_TABLE_TO_DEST, 1'b1, 8'h06);
    run(OP_TABLE_TO_DEST, 1'b1, 8'h00);
    host(1'b1, BASE, 16'h0003);
    repeat (4) run(OP_REMOVE_BOTTOM, 1'b1, 8'h06);
    host(1'b1, BASE, 16'h0007);
    run(OP_REMOVE_BOTTOM, 1'b1, 8'h06);
    $display("test remove from bottom done");
    // every noted result must have been seen
    if (flag_q.size() != 0 || rd_q.size() != 0)
      fail("results missing");
    give_verdict();
  end
endmodule

bind tpm_top tpm_top_sva chk_u (.clk, .rst_n, .exec_req, .exec_enable,
  .scan_end, .ext_rd, .ext_wr, .ext_ack, .busy, .done, .end_of_table_flag);

`default_nettype wire
